// >>> rtl/ncms_cmd_decode.sv
// Command byte decoder: register addresses and output-source codes.
`timescale 1ns/100ps
`default_nettype none
module ncms_cmd_decode
(
  input  wire logic [7:0]        code,
  output ncms_pkg::ncms_cmd_s    dec
);

  function automatic logic hit(input logic [7:0] c,
                               input logic [7:0] pat,
                               input logic [7:0] msk);
    return (c & msk) == pat;
  endfunction

  logic is_cfg;
  logic is_in;
  logic b0;
  logic b1;
  logic b2;
  logic b3;
  logic ext;
  logic dfr;
  logic any_b;

  assign is_cfg = code <= ncms_pkg::CMD_CFG_LAST;
  assign is_in  = code == ncms_pkg::CMD_INPUTS;
  assign b0     = hit(code, ncms_pkg::PAT_B0, ncms_pkg::MSK_B0);
  assign b1     = hit(code, ncms_pkg::PAT_B1, ncms_pkg::MSK_B1);
  assign b2     = hit(code, ncms_pkg::PAT_B2, ncms_pkg::MSK_B2);
  assign b3     = hit(code, ncms_pkg::PAT_B3, ncms_pkg::MSK_B3);
  assign ext    = hit(code, ncms_pkg::PAT_EXT, ncms_pkg::MSK_EXT);
  assign dfr    = hit(code, ncms_pkg::PAT_DEF, ncms_pkg::MSK_DEF);
  assign any_b  = b0 | b1 | b2 | b3;

  // The input view code shares bits with the source patterns and wins.
  assign dec.reg_cfg    = is_cfg;
  assign dec.reg_inputs = is_in;
  assign dec.src_cmd    = ~is_in & (any_b | ext | dfr);
  assign dec.valid      = is_cfg | is_in | dec.src_cmd;
  // Specific byte and external codes take priority over the defer pattern.
  assign dec.src_mode   = any_b ? ncms_pkg::NCMS_SRC_CFG :
                          ext   ? ncms_pkg::NCMS_SRC_EXT :
                                  ncms_pkg::NCMS_SRC_PIN;
  assign dec.src_byte   = b0 ? 2'h0 : b1 ? 2'h1 : b2 ? 2'h2 : 2'h3;

endmodule // ncms_cmd_decode
`default_nettype wire

// >>> rtl/ncms_line_sampler.sv
// Edge and bus-condition detector for the two serial lines.
`timescale 1ns/100ps
`default_nettype none
module ncms_line_sampler
(
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              scl,
  input  wire logic              sda_in,
  output ncms_pkg::ncms_line_s   line
);

  logic scl_prev_q;
  logic sda_prev_q;

  // Idle lines are high, so the history starts high to avoid a false edge.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl;
      sda_prev_q <= sda_in;
    end
  end

  assign line.sda      = sda_in;
  assign line.scl_rise = scl & ~scl_prev_q;
  assign line.scl_fall = ~scl & scl_prev_q;
  assign line.start    = scl & scl_prev_q & sda_prev_q & ~sda_in;
  assign line.stop     = scl & scl_prev_q & ~sda_prev_q & sda_in;

endmodule // ncms_line_sampler
`default_nettype wire

// >>> rtl/ncms_pkg.sv
// Shared constants and types for the configuration mux switch.
package ncms_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS  = 3600000;
  // A least time, so the cycle count rounds up.
  localparam int PROG_CYCLES   =
    (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------------
  localparam int         DATA_W    = 6;
  localparam int         NUM_CFG   = 4;
  localparam int         MAX_SEQ   = 4;
  localparam logic [5:0] CFG_RESET = 6'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Fixed upper slave address bits; the value is arbitrary.
  localparam logic [4:0] ADDR_FIXED_DEF = 5'h0a;

  // ----------------------------------------------------------------------
  // Command codes: register addresses, then source patterns and masks
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_LAST = 8'h03;
  localparam logic [7:0] CMD_INPUTS   = 8'hff;
  localparam logic [7:0] PAT_B0  = 8'hf8;
  localparam logic [7:0] MSK_B0  = 8'hff;
  localparam logic [7:0] PAT_B1  = 8'hfc;
  localparam logic [7:0] MSK_B1  = 8'hff;
  localparam logic [7:0] PAT_B2  = 8'hf9;
  localparam logic [7:0] MSK_B2  = 8'hfd;
  localparam logic [7:0] PAT_B3  = 8'hfd;
  localparam logic [7:0] MSK_B3  = 8'hfd;
  localparam logic [7:0] PAT_EXT = 8'hfa;
  localparam logic [7:0] MSK_EXT = 8'hfb;
  localparam logic [7:0] PAT_DEF = 8'hf9;
  localparam logic [7:0] MSK_DEF = 8'hf9;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    NCMS_SRC_PIN = 2'b00,
    NCMS_SRC_CFG = 2'b01,
    NCMS_SRC_EXT = 2'b10
  } ncms_src_e;

  typedef enum logic [2:0] {
    NCMS_ST_IDLE = 3'b000,
    NCMS_ST_RX   = 3'b001,
    NCMS_ST_ACK  = 3'b010,
    NCMS_ST_TX   = 3'b011,
    NCMS_ST_MACK = 3'b100
  } ncms_state_e;

  typedef enum logic [1:0] {
    NCMS_PH_ADDR = 2'b00,
    NCMS_PH_CMD  = 2'b01,
    NCMS_PH_DATA = 2'b10
  } ncms_phase_e;

  typedef struct packed {
    logic      valid;
    logic      reg_cfg;
    logic      reg_inputs;
    logic      src_cmd;
    ncms_src_e src_mode;
    logic [1:0] src_byte;
  } ncms_cmd_s;

  typedef struct packed {
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } ncms_line_s;

endpackage

// >>> rtl/ncms_top.sv
// Serial-bus configuration store with a six-bit output multiplexer.
`timescale 1ns/100ps
`default_nettype none
module ncms_top
#(
  parameter int unsigned PROG_CYCLES = ncms_pkg::PROG_CYCLES,
  parameter logic [4:0]  ADDR_FIXED  = ncms_pkg::ADDR_FIXED_DEF
)
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        addr_pin_low,
  input  wire logic        addr_pin_high,
  input  wire logic        write_protect,
  input  wire logic        select_pin,
  input  wire logic [5:0]  ext_in,
  output logic      [5:0]  mux_out,
  output logic      [5:0]  mux_out_oe
);

  localparam int BW = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ncms_pkg::ncms_line_s  line;
  ncms_pkg::ncms_cmd_s   dec_rx;
  ncms_pkg::ncms_cmd_s   dec_cmd;
  ncms_pkg::ncms_state_e state_q;
  ncms_pkg::ncms_phase_e phase_q;
  ncms_pkg::ncms_src_e   src_q;
  logic [3:0]            bit_cnt_q;
  logic [7:0]            shreg_q;
  logic [7:0]            tx_q;
  logic                  sda_oe_q;
  logic                  rw_q;
  logic                  more_q;
  logic [7:0]            cmd_q;
  logic [1:0]            ptr_q;
  logic [1:0]            cfg_sel_q;
  logic [5:0]            cfg_q   [ncms_pkg::NUM_CFG];
  logic [5:0]            stage_q [ncms_pkg::NUM_CFG];
  logic [3:0]            stage_v_q;
  logic [2:0]            wcount_q;
  logic                  abort_q;
  logic [BW-1:0]         busy_cnt_q;
  logic [5:0]            mux_out_q;
  logic [5:0]            mux_out_oe_q;

  ncms_line_sampler u_line
  (
    .clock  (clock),
    .rst_n  (rst_n),
    .scl    (scl),
    .sda_in (sda_in),
    .line   (line)
  );

  ncms_cmd_decode u_dec_rx
  (
    .code (shreg_q),
    .dec  (dec_rx)
  );

  ncms_cmd_decode u_dec_cmd
  (
    .code (cmd_q),
    .dec  (dec_cmd)
  );

  // ----------------------------------------------------------------------
  // Decisions on received bytes, read loads, the STOP commit and the output source
  // ----------------------------------------------------------------------
  logic       busy;
  logic       byte_done;
  logic [6:0] my_addr;
  logic       addr_hit;
  logic       cmd_ok;
  logic       data_cfg;
  logic       data_ok;
  logic       data_over;
  logic       ack_now;
  logic       src_take;
  logic       tx_load;
  logic       rd_adv;
  logic       ptr_adv;
  logic       commit;
  logic [7:0] rd_byte;
  logic       use_ext;
  logic [5:0] mux_val;

  assign busy      = busy_cnt_q != '0;
  assign byte_done = (state_q == ncms_pkg::NCMS_ST_RX) && line.scl_fall &&
                     (bit_cnt_q == 4'h8);
  assign my_addr   = {ADDR_FIXED, addr_pin_high, addr_pin_low};
  assign addr_hit  = byte_done && (phase_q == ncms_pkg::NCMS_PH_ADDR) &&
                     (shreg_q[7:1] == my_addr) && !busy;
  assign cmd_ok    = byte_done && (phase_q == ncms_pkg::NCMS_PH_CMD) &&
                     dec_rx.valid;
  // Data after a source or input-view command is never acknowledged.
  assign data_cfg  = byte_done && (phase_q == ncms_pkg::NCMS_PH_DATA) &&
                     dec_cmd.reg_cfg && !write_protect;
  assign data_ok   = data_cfg &&
                     (wcount_q < 3'(ncms_pkg::MAX_SEQ));
  assign data_over = data_cfg &&
                     (wcount_q == 3'(ncms_pkg::MAX_SEQ));
  assign ack_now   = addr_hit | cmd_ok | data_ok;
  assign src_take  = cmd_ok && dec_rx.src_cmd;
  assign tx_load   = line.scl_fall &&
                     (((state_q == ncms_pkg::NCMS_ST_ACK) && rw_q) ||
                      ((state_q == ncms_pkg::NCMS_ST_MACK) && more_q));
  assign rd_adv    = tx_load && dec_cmd.reg_cfg;
  assign ptr_adv   = data_ok || rd_adv;
  assign commit    = line.stop && !abort_q && (stage_v_q != 4'h0);
  // Unused upper bits read as zero for both kinds of register.
  assign rd_byte   = dec_cmd.reg_inputs ? {2'b00, ext_in} :
                     dec_cmd.reg_cfg    ? {2'b00, cfg_q[ptr_q]} :
                                          cmd_q;
  assign use_ext   = (src_q == ncms_pkg::NCMS_SRC_PIN) ? select_pin :
                     (src_q == ncms_pkg::NCMS_SRC_EXT);
  assign mux_val   = use_ext ? ext_in : cfg_q[cfg_sel_q];

  // ----------------------------------------------------------------------
  // Bit-level protocol engine
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q   <= ncms_pkg::NCMS_ST_IDLE;
      phase_q   <= ncms_pkg::NCMS_PH_ADDR;
      bit_cnt_q <= 4'h0;
      shreg_q   <= 8'h00;
      tx_q      <= 8'h00;
      sda_oe_q  <= 1'b0;
      more_q    <= 1'b0;
    end
    else if (line.start)
    begin
      state_q   <= ncms_pkg::NCMS_ST_RX;
      phase_q   <= ncms_pkg::NCMS_PH_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
    end
    else if (line.stop)
    begin
      state_q  <= ncms_pkg::NCMS_ST_IDLE;
      sda_oe_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ncms_pkg::NCMS_ST_IDLE:
        begin
          sda_oe_q <= 1'b0;
        end
        ncms_pkg::NCMS_ST_RX:
        begin
          if (line.scl_rise)
          begin
            shreg_q   <= {shreg_q[6:0], line.sda};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (byte_done)
          begin
            // A refused byte leaves the line released and waits for START.
            state_q  <= ack_now ? ncms_pkg::NCMS_ST_ACK :
                                  ncms_pkg::NCMS_ST_IDLE;
            sda_oe_q <= ack_now;
          end
        end
        ncms_pkg::NCMS_ST_ACK:
        begin
          if (tx_load)
          begin
            state_q   <= ncms_pkg::NCMS_ST_TX;
            tx_q      <= rd_byte;
            sda_oe_q  <= ~rd_byte[7];
            bit_cnt_q <= 4'h0;
          end
          else if (line.scl_fall)
          begin
            state_q   <= ncms_pkg::NCMS_ST_RX;
            sda_oe_q  <= 1'b0;
            bit_cnt_q <= 4'h0;
            phase_q   <= (phase_q == ncms_pkg::NCMS_PH_ADDR) ?
                         ncms_pkg::NCMS_PH_CMD :
                         ncms_pkg::NCMS_PH_DATA;
          end
        end
        ncms_pkg::NCMS_ST_TX:
        begin
          if (line.scl_rise)
          begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          else if (line.scl_fall)
          begin
            if (bit_cnt_q == 4'h8)
            begin
              state_q  <= ncms_pkg::NCMS_ST_MACK;
              sda_oe_q <= 1'b0;
            end
            else
            begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
        end
        ncms_pkg::NCMS_ST_MACK:
        begin
          if (line.scl_rise)
          begin
            more_q <= ~line.sda;
          end
          else if (tx_load)
          begin
            state_q   <= ncms_pkg::NCMS_ST_TX;
            tx_q      <= rd_byte;
            sda_oe_q  <= ~rd_byte[7];
            bit_cnt_q <= 4'h0;
          end
          else if (line.scl_fall)
          begin
            state_q <= ncms_pkg::NCMS_ST_IDLE;
          end
        end
        default:
        begin
          state_q  <= ncms_pkg::NCMS_ST_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Command, pointer and output source
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rw_q      <= 1'b0;
      cmd_q     <= ncms_pkg::CMD_RESET;
      ptr_q     <= 2'h0;
      src_q     <= ncms_pkg::NCMS_SRC_PIN;
      cfg_sel_q <= 2'h0;
    end
    else
    begin
      if (addr_hit)
        rw_q <= shreg_q[0];
      if (cmd_ok)
        cmd_q <= shreg_q;
      // The 2-bit pointer wraps on its own past the last location.
      if (cmd_ok && dec_rx.reg_cfg)
        ptr_q <= shreg_q[1:0];
      else if (ptr_adv)
        ptr_q <= ptr_q + 2'h1;
      if (src_take)
        src_q <= dec_rx.src_mode;
      if (src_take && (dec_rx.src_mode == ncms_pkg::NCMS_SRC_CFG))
        cfg_sel_q <= dec_rx.src_byte;
    end
  end

  // ----------------------------------------------------------------------
  // Write staging, programming and busy interval
  // ----------------------------------------------------------------------
  // Bytes are staged and only programmed together at STOP, so an
  // aborted sequence leaves every location untouched.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage_v_q  <= 4'h0;
      wcount_q   <= 3'h0;
      abort_q    <= 1'b0;
      busy_cnt_q <= '0;
    end
    else
    begin
      if (line.start || line.stop)
      begin
        stage_v_q <= 4'h0;
        wcount_q  <= 3'h0;
        abort_q   <= 1'b0;
      end
      else if (data_ok)
      begin
        stage_v_q[ptr_q] <= 1'b1;
        wcount_q         <= wcount_q + 3'h1;
      end
      else if (data_over)
        abort_q <= 1'b1;
      if (commit)
        busy_cnt_q <= BW'(PROG_CYCLES);
      else if (busy)
        busy_cnt_q <= busy_cnt_q - BW'(1);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < ncms_pkg::NUM_CFG; gi++)
    begin : g_cfg
      always_ff @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cfg_q[gi]   <= ncms_pkg::CFG_RESET;
          stage_q[gi] <= ncms_pkg::CFG_RESET;
        end
        else
        begin
          // Bits 7 and 6 of written data are dropped here.
          if (data_ok && (ptr_q == 2'(gi)))
            stage_q[gi] <= shreg_q[5:0];
          if (commit && stage_v_q[gi])
            cfg_q[gi] <= stage_q[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Output multiplexer, registered; open drain pulls low for a zero
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mux_out_q    <= 6'h00;
      mux_out_oe_q <= 6'h00;
    end
    else
    begin
      mux_out_q    <= mux_val;
      mux_out_oe_q <= ~mux_val;
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = sda_oe_q;
  assign mux_out    = mux_out_q;
  assign mux_out_oe = mux_out_oe_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_data_byte;
    byte_done && (phase_q == ncms_pkg::NCMS_PH_DATA);
  endsequence

  addr_dir_a: assert property (
    addr_hit |=> rw_q == $past(shreg_q[0]))
    else $error("direction bit not captured");
  busy_refuse_a: assert property (
    byte_done && (phase_q == ncms_pkg::NCMS_PH_ADDR) && busy
    |=> !sda_oe_q && (state_q == ncms_pkg::NCMS_ST_IDLE))
    else $error("address acknowledged while programming");
  cmd_refuse_a: assert property (
    byte_done && (phase_q == ncms_pkg::NCMS_PH_CMD) && !dec_rx.valid
    |=> !sda_oe_q)
    else $error("reserved command acknowledged");
  wp_refuse_a: assert property (
    s_data_byte ##0 write_protect |=> !sda_oe_q ##1 !commit)
    else $error("protected data acknowledged");
  excess_abort_a: assert property (
    s_data_byte ##0 data_over |=> abort_q && !sda_oe_q)
    else $error("excess byte not refused");
  prog_load_a: assert property (
    commit |=> busy_cnt_q == BW'(PROG_CYCLES))
    else $error("programming interval not started");
  ptr_wrap_a: assert property (
    ptr_adv && (ptr_q == 2'h3) && !cmd_ok |=> ptr_q == 2'h0)
    else $error("pointer did not wrap");
  ext_follow_a: assert property (
    (src_q == ncms_pkg::NCMS_SRC_PIN) && select_pin
    |=> mux_out_q == $past(ext_in))
    else $error("output does not follow inputs");
  src_hold_a: assert property (
    !src_take |=> $stable(src_q))
    else $error("source changed without command");
  rd_pad_a: assert property (
    tx_load && dec_cmd.reg_inputs |=> tx_q == {2'b00, $past(ext_in)})
    else $error("input view read wrong");

endmodule // ncms_top
`default_nettype wire

// >>> testbench/ncms_master.sv
// Serial bus master model that drives the configuration switch.
`timescale 1ns/100ps
`default_nettype none
module ncms_master
(
  input  wire logic clock,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  // Changes land 1 ns after an edge; SCL half periods are 4 clocks.
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Also serves as a repeated START.
  task automatic start();
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask

  // Nine slots, MSB first; data only moves while SCL is low.
  task automatic xfer(input logic [8:0] wb, output logic [8:0] rb);
    for (int i = 8; i >= 0; i--)
    begin
      tick(2);
      sda_pull = ~wb[i];
      tick(2);
      scl = 1'b1;
      tick(4);
      rb[i] = sda;
      scl = 1'b0;
    end
  endtask
endmodule // ncms_master
`default_nettype wire

// >>> testbench/ncms_top_tb_top.sv
// Self-checking bench for the configuration mux switch.
`timescale 1ns/100ps
`default_nettype none
module ncms_top_tb_top;
  // Must outlast a whole address byte, so a refused address can be seen.
  localparam int PROG = 200;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } ncms_row_s;
  ncms_row_s rows [4] = '{'{8'h00, 8'hff, 8'h3f}, '{8'h01, 8'h2a, 8'h2a},
                          '{8'h02, 8'h15, 8'h15}, '{8'h03, 8'h01, 8'h01}};
  logic [7:0] src_code [7] = '{8'hf8, 8'hfc, 8'hf9, 8'hfb, 8'hfd, 8'hfa,
                               8'hfe};
  logic [5:0] src_exp  [7] = '{6'h3f, 6'h2a, 6'h15, 6'h15, 6'h01, 6'h2d,
                               6'h2d};
  logic       clock = 1'b0;
  logic       rst_n, al, ah, wp, sel, scl, m_pull, sda_oe, sda_o;
  logic [5:0] ext_in, mux_out, mux_oe;
  logic [7:0] d;
  int         n_fail = 0;
  int         total_checks = 0;
  int         cyc = 0;
  wire        sda = ~(m_pull | sda_oe);

  always #4 clock = ~clock;

  ncms_master m (.clock(clock), .sda(sda), .scl(scl), .sda_pull(m_pull));

  ncms_top #(.PROG_CYCLES(PROG)) ncms_top_inst (
    .clock(clock), .rst_n(rst_n), .scl(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe(sda_oe), .addr_pin_low(al), .addr_pin_high(ah),
    .write_protect(wp), .select_pin(sel), .ext_in(ext_in),
    .mux_out(mux_out), .mux_out_oe(mux_oe));

  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      stop_test();
    end
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] b, input logic nack);
    logic [8:0] rb;
    m.xfer({b, 1'b1}, rb);
    chk({8'h00, rb[0]}, {8'h00, nack});
  endtask

  task automatic rd(input logic last, output logic [7:0] v);
    logic [8:0] rb;
    m.xfer({8'hff, last}, rb);
    v = rb[8:1];
  endtask

  task automatic addr(input logic rw, input logic nack);
    m.start();
    wr({ncms_pkg::ADDR_FIXED_DEF, ah, al, rw}, nack);
  endtask

  task automatic rdb(input logic [7:0] cmd, input logic [7:0] exp);
    logic [7:0] v;
    addr(1'b0, 1'b0);
    wr(cmd, 1'b0);
    addr(1'b1, 1'b0);
    rd(1'b1, v);
    m.stop();
    chk({1'b0, v}, {1'b0, exp});
  endtask

  task automatic cmd_only(input logic [7:0] cmd, input logic nack);
    addr(1'b0, 1'b0);
    wr(cmd, nack);
    m.stop();
    m.tick(2);
  endtask

  initial
  begin
    {rst_n, wp, sel, ah, al, ext_in} = {5'b00001, 6'h2d};
    repeat (12) @(posedge clock);
    #1 rst_n = 1'b1;
    m.tick(3);
    chk({3'h0, mux_out}, 9'h000);
    chk({3'h0, mux_oe}, 9'h03f);
    chk({8'h00, sda_o}, 9'h000);
    foreach (rows[i])
    begin
      addr(1'b0, 1'b0);
      wr(rows[i].code, 1'b0);
      wr(rows[i].wdata, 1'b0);
      m.stop();
      m.tick(PROG + 4);
      rdb(rows[i].code, rows[i].rdata);
    end
    rdb(8'hff, {2'b00, ext_in});
    chk({3'h0, mux_out}, 9'h03f);
    sel = 1'b1;
    m.tick(2);
    chk({3'h0, mux_out}, {3'h0, ext_in});
    for (int i = 0; i < 7; i++)
    begin
      cmd_only(src_code[i], 1'b0);
      chk({3'h0, mux_out}, {3'h0, src_exp[i]});
      chk({3'h0, mux_oe}, {3'h0, ~src_exp[i]});
    end
    ext_in = 6'h12;
    m.tick(2);
    chk({3'h0, mux_out}, 9'h012);
    cmd_only(8'h04, 1'b1);
    cmd_only(8'hf0, 1'b1);
    wp = 1'b1;
    addr(1'b0, 1'b0);
    wr(8'h01, 1'b0);
    wr(8'h3c, 1'b1);
    m.stop();
    wp = 1'b0;
    rdb(8'h01, 8'h2a);
    addr(1'b0, 1'b0);
    wr(8'h02, 1'b0);
    for (int k = 1; k <= 4; k++)
      wr(8'(k * 17), 1'b0);
    m.stop();
    addr(1'b0, 1'b1);
    m.stop();
    m.tick(PROG + 4);
    addr(1'b0, 1'b0);
    wr(8'h02, 1'b0);
    addr(1'b1, 1'b0);
    for (int k = 1; k <= 4; k++)
    begin
      rd(k == 4, d);
      chk({1'b0, d}, {1'b0, 2'b00, 6'(k * 17)});
    end
    m.stop();
    addr(1'b0, 1'b0);
    wr(8'h00, 1'b0);
    for (int k = 0; k < 4; k++)
      wr(8'h0f, 1'b0);
    wr(8'h0f, 1'b1);
    m.stop();
    m.tick(PROG + 4);
    rdb(8'h00, 8'h33);
    al = 1'b0;
    ah = 1'b1;
    m.start();
    wr({ncms_pkg::ADDR_FIXED_DEF, 1'b0, 1'b1, 1'b0}, 1'b1);
    m.stop();
    addr(1'b0, 1'b0);
    m.stop();
    stop_test();
  end
endmodule // ncms_top_tb_top
`default_nettype wire
